// [frcct_defs.svh]
// Register map, field positions and reset values of the capture/compare timer.
// Assumes byte-wide registers, one per aligned 32-bit word of the slave.
`ifndef FRCCT_DEFS_SVH
`define FRCCT_DEFS_SVH

// Register byte addresses
`define FRCCT_OFF_CNT_HI 8'h00
`define FRCCT_OFF_CNT_LO 8'h04
`define FRCCT_OFF_ALT_HI 8'h08
`define FRCCT_OFF_ALT_LO 8'h0C
`define FRCCT_OFF_CAP1_HI 8'h10
`define FRCCT_OFF_CAP1_LO 8'h14
`define FRCCT_OFF_CAP2_HI 8'h18
`define FRCCT_OFF_CAP2_LO 8'h1C
`define FRCCT_OFF_CMP1_HI 8'h20
`define FRCCT_OFF_CMP1_LO 8'h24
`define FRCCT_OFF_CMP2_HI 8'h28
`define FRCCT_OFF_CMP2_LO 8'h2C
`define FRCCT_OFF_CR1 8'h30
`define FRCCT_OFF_CR2 8'h34
`define FRCCT_OFF_CR3 8'h38
`define FRCCT_OFF_SR 8'h3C
`define FRCCT_OFF_LAST 8'h3C

// control_reg_one
`define FRCCT_CR1_SHARED_CAP_EN 7
`define FRCCT_CR1_SHARED_CMP_EN 6
`define FRCCT_CR1_OVF_EN 5
`define FRCCT_CR1_CAP1_EDGE 4
`define FRCCT_CR1_LEVEL2 1
`define FRCCT_CR1_LEVEL1 0
// control_reg_two
`define FRCCT_CR2_PIN1_EN 7
`define FRCCT_CR2_PIN2_EN 6
`define FRCCT_CR2_CC_HI 3
`define FRCCT_CR2_CC_LO 2
`define FRCCT_CR2_CAP2_EDGE 1
`define FRCCT_CR2_EXT_EDGE 0
// control_reg_three
`define FRCCT_CR3_GLOBAL_EN 7
`define FRCCT_CR3_CAP1_EN 6
`define FRCCT_CR3_CAP2_EN 5
`define FRCCT_CR3_CMP1_EN 4
`define FRCCT_CR3_CMP2_EN 3

// Clock control codes
`define FRCCT_CC_DIV2 2'b00
`define FRCCT_CC_DIV4 2'b01
`define FRCCT_CC_DIV8 2'b10
`define FRCCT_CC_EXT 2'b11

// Reset and special values
`define FRCCT_COUNT_RESET 16'hFFFC
`define FRCCT_COUNT_TOP 16'hFFFF
`define FRCCT_COMPARE_RESET 16'h8000
`define FRCCT_RESP_OKAY 2'b00
`define FRCCT_RESP_SLVERR 2'b10

`endif

// [frcct_pkg.sv]
// Types of the capture/compare timer.
// Assumes frcct_defs.svh for all numeric constants.
package frcct_pkg;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic [15:0] count;
    logic [2:0] presc;
    logic ext_prev;
    logic [1:0] cap_prev;
    logic [1:0][15:0] capture_value;
    logic [1:0] capture_lock;
    logic [1:0][15:0] compare_value;
    logic [1:0] compare_inhibit;
    logic [7:0] low_buf;
    logic latched;
    logic [7:0] control_reg_one;
    logic [7:0] control_reg_two;
    logic [7:0] control_reg_three;
    logic overflow_flag;
    logic [1:0] capture_flag;
    logic [1:0] compare_flag;
    logic [1:0] compare_level_out;
    logic irq;
  } frcct_state_type;

endpackage : frcct_pkg

// [frcct_timer.sv]
// Free-running 16-bit capture/compare timer with AXI4-Lite byte registers.
// Assumes pins synchronous to clk; clk plays the internal clock.
//
// Notes on behaviour
// - Timer clock: clk/2, /4, /8 or external
// - Counter low writes reload FFFCh
// - High read latches low byte until low read
// - Lone low read returns live count
// - Rollover FFFFh to 0000h sets overflow flag
// - Overflow irq needs both enables, else pending
// - Status read or counter low access clears overflow
// - Alternate low never clears overflow, same values
// - Runs in wait, stops in halt
// - External pin edge advances counter, selectable edge
// - All counter updates on one internal edge
// - Capture pin edge copies counter to capture
// - Each capture channel has own edge select
// - Capture event sets capture flag
// - Capture irq: global and shared-or-own enable
// - Status or capture low access clears flag
// - High read blocks capture until low read
// - Newest capture overwrites the older one
// - Compare match: flag, pin level, irq
// - Compare registers software only, reset 8000h
// - Compare high write inhibits until low write
// - Status or compare low access clears flag
`timescale 1ns/1ps
`include "frcct_defs.svh"

module frcct_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic ext_clock_pin,
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  input wire logic halt_mode,
  output logic compare_pin_one,
  output logic compare_pin_one_oe,
  output logic compare_pin_two,
  output logic compare_pin_two_oe,
  output logic combined_timer_irq
);

  localparam frcct_pkg::frcct_state_type RESET_STATE = '{
    count: `FRCCT_COUNT_RESET,
    compare_value: {2{`FRCCT_COMPARE_RESET}},
    default: '0
  };
  localparam logic [1:0][7:0] CAP_HI =
    {`FRCCT_OFF_CAP2_HI, `FRCCT_OFF_CAP1_HI};
  localparam logic [1:0][7:0] CAP_LO =
    {`FRCCT_OFF_CAP2_LO, `FRCCT_OFF_CAP1_LO};
  localparam logic [1:0][7:0] CMP_HI =
    {`FRCCT_OFF_CMP2_HI, `FRCCT_OFF_CMP1_HI};
  localparam logic [1:0][7:0] CMP_LO =
    {`FRCCT_OFF_CMP2_LO, `FRCCT_OFF_CMP1_LO};

  frcct_pkg::frcct_state_type s;
  frcct_pkg::frcct_state_type next_s;
  logic [1:0] cap_in;
  logic [1:0] cap_edge_sel;
  logic [1:0] cap_edge;
  logic [1:0] cmp_match;
  logic [1:0] pin_en;
  logic [1:0] level;
  logic raw_tick;
  logic tick;
  logic ext_edge;
  logic rd_take;
  logic do_write;
  logic wr_en;
  logic wr_cnt_lo;
  logic [7:0] rd_byte;
  logic [7:0] sr_byte;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `FRCCT_OFF_LAST);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign s_axil_awready = s.awready;
  assign s_axil_wready = s.wready;
  assign s_axil_bvalid = s.bvalid;
  assign s_axil_bresp = s.bresp;
  assign s_axil_arready = s.arready;
  assign s_axil_rvalid = s.rvalid;
  assign s_axil_rdata = {24'h00_0000, s.rdata};
  assign s_axil_rresp = s.rresp;
  assign compare_pin_one = s.compare_level_out[0];
  assign compare_pin_two = s.compare_level_out[1];
  assign compare_pin_one_oe = s.control_reg_two[`FRCCT_CR2_PIN1_EN];
  assign compare_pin_two_oe = s.control_reg_two[`FRCCT_CR2_PIN2_EN];
  assign combined_timer_irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Timer clock and per-channel events
  assign cap_in = {capture_pin_two, capture_pin_one};
  assign cap_edge_sel = {s.control_reg_two[`FRCCT_CR2_CAP2_EDGE],
                         s.control_reg_one[`FRCCT_CR1_CAP1_EDGE]};
  assign pin_en = {s.control_reg_two[`FRCCT_CR2_PIN2_EN],
                   s.control_reg_two[`FRCCT_CR2_PIN1_EN]};
  assign level = {s.control_reg_one[`FRCCT_CR1_LEVEL2],
                  s.control_reg_one[`FRCCT_CR1_LEVEL1]};
  // Edge select 1 picks rising, 0 falling
  assign ext_edge = s.control_reg_two[`FRCCT_CR2_EXT_EDGE] ?
    (~s.ext_prev & ext_clock_pin) : (s.ext_prev & ~ext_clock_pin);

  // Plain sampling is enough only because the source keeps its gap
  always_comb begin
    unique case (s.control_reg_two[`FRCCT_CR2_CC_HI:`FRCCT_CR2_CC_LO])
      `FRCCT_CC_DIV2: raw_tick = s.presc[0];
      `FRCCT_CC_DIV4: raw_tick = &s.presc[1:0];
      `FRCCT_CC_DIV8: raw_tick = &s.presc;
      `FRCCT_CC_EXT: raw_tick = ext_edge;
    endcase
  end
  // Wait mode needs no input: the counter simply keeps running
  assign tick = raw_tick & ~halt_mode;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      assign cap_edge[i] = cap_edge_sel[i] ?
        (~s.cap_prev[i] & cap_in[i]) : (s.cap_prev[i] & ~cap_in[i]);
      assign cmp_match[i] = (s.compare_value[i] == s.count) &
                            ~s.compare_inhibit[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  assign rd_take = s.arready & s_axil_arvalid;
  assign do_write = s.aw_held & s.w_held & ~s.bvalid;
  assign wr_en = do_write & s.wstrb0;
  assign wr_cnt_lo = wr_en & ((s.awaddr == `FRCCT_OFF_CNT_LO) |
                              (s.awaddr == `FRCCT_OFF_ALT_LO));
  assign sr_byte = {s.capture_flag[0], s.compare_flag[0], s.overflow_flag,
                    s.capture_flag[1], s.compare_flag[1], 3'b000};

  always_comb begin
    case (s_axil_araddr)
      `FRCCT_OFF_CNT_HI, `FRCCT_OFF_ALT_HI: rd_byte = s.count[15:8];
      `FRCCT_OFF_CNT_LO, `FRCCT_OFF_ALT_LO:
        rd_byte = s.latched ? s.low_buf : s.count[7:0];
      `FRCCT_OFF_CR1: rd_byte = s.control_reg_one;
      `FRCCT_OFF_CR2: rd_byte = s.control_reg_two;
      `FRCCT_OFF_CR3: rd_byte = s.control_reg_three;
      `FRCCT_OFF_SR: rd_byte = sr_byte;
      default: rd_byte = 8'h00;
    endcase
    for (int i = 0; i < 2; i++) begin
      if (s_axil_araddr == CAP_HI[i]) rd_byte = s.capture_value[i][15:8];
      if (s_axil_araddr == CAP_LO[i]) rd_byte = s.capture_value[i][7:0];
      if (s_axil_araddr == CMP_HI[i]) rd_byte = s.compare_value[i][15:8];
      if (s_axil_araddr == CMP_LO[i]) rd_byte = s.compare_value[i][7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: counter, bus effects, then hardware sets so that sets win
  always_comb begin
    next_s = s;
    next_s.presc = s.presc + 3'd1;
    next_s.ext_prev = ext_clock_pin;
    next_s.cap_prev = cap_in;
    // Counter moves only on the single timer tick of clk
    if (tick) next_s.count = s.count + 16'h0001;
    // Read channel
    if (s.rvalid & s_axil_rready) next_s.rvalid = 1'b0;
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = mapped(s_axil_araddr) ? rd_byte : 8'h00;
      next_s.rresp = mapped(s_axil_araddr) ? `FRCCT_RESP_OKAY :
                                             `FRCCT_RESP_SLVERR;
      if ((s_axil_araddr == `FRCCT_OFF_CNT_HI ||
           s_axil_araddr == `FRCCT_OFF_ALT_HI) && !s.latched) begin
        next_s.low_buf = s.count[7:0];
        next_s.latched = 1'b1;
      end
      if (s_axil_araddr == `FRCCT_OFF_CNT_LO ||
          s_axil_araddr == `FRCCT_OFF_ALT_LO) next_s.latched = 1'b0;
      // Alternate low read leaves the flag alone
      if (s_axil_araddr == `FRCCT_OFF_CNT_LO)
        next_s.overflow_flag = 1'b0;
      if (s_axil_araddr == `FRCCT_OFF_SR) begin
        next_s.overflow_flag = 1'b0;
        next_s.capture_flag = 2'b00;
        next_s.compare_flag = 2'b00;
      end
      for (int i = 0; i < 2; i++) begin
        if (s_axil_araddr == CAP_HI[i]) next_s.capture_lock[i] = 1'b1;
        if (s_axil_araddr == CAP_LO[i]) begin
          next_s.capture_lock[i] = 1'b0;
          next_s.capture_flag[i] = 1'b0;
        end
        if (s_axil_araddr == CMP_LO[i]) next_s.compare_flag[i] = 1'b0;
      end
    end
    // Write channel: address and data taken in either order
    if (s.bvalid & s_axil_bready) next_s.bvalid = 1'b0;
    if (s.awready & s_axil_awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axil_awaddr;
    end
    if (s.wready & s_axil_wvalid) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axil_wdata[7:0];
      next_s.wstrb0 = s_axil_wstrb[0];
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.awaddr) ? `FRCCT_RESP_OKAY : `FRCCT_RESP_SLVERR;
      // Any access clears requests, even with the byte lane off
      if (s.awaddr == `FRCCT_OFF_CNT_LO) next_s.overflow_flag = 1'b0;
      if (s.awaddr == `FRCCT_OFF_SR) begin
        next_s.capture_flag = 2'b00;
        next_s.compare_flag = 2'b00;
      end
      for (int i = 0; i < 2; i++) begin
        if (s.awaddr == CAP_LO[i]) next_s.capture_flag[i] = 1'b0;
        if (s.awaddr == CMP_LO[i]) next_s.compare_flag[i] = 1'b0;
      end
    end
    if (wr_cnt_lo) next_s.count = `FRCCT_COUNT_RESET;
    if (wr_en) begin
      if (s.awaddr == `FRCCT_OFF_CR1) next_s.control_reg_one = s.wdata;
      if (s.awaddr == `FRCCT_OFF_CR2) next_s.control_reg_two = s.wdata;
      if (s.awaddr == `FRCCT_OFF_CR3) next_s.control_reg_three = s.wdata;
      for (int i = 0; i < 2; i++) begin
        if (s.awaddr == CMP_HI[i]) begin
          next_s.compare_value[i][15:8] = s.wdata;
          next_s.compare_inhibit[i] = 1'b1;
        end
        if (s.awaddr == CMP_LO[i]) begin
          next_s.compare_value[i][7:0] = s.wdata;
          next_s.compare_inhibit[i] = 1'b0;
        end
      end
    end
    next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
    next_s.wready = ~next_s.w_held & ~next_s.bvalid;
    next_s.arready = ~next_s.rvalid;
    // Hardware events
    if (tick && s.count == `FRCCT_COUNT_TOP)
      next_s.overflow_flag = 1'b1;
    for (int i = 0; i < 2; i++) begin
      // A high read in this very cycle already blocks the capture
      if (cap_edge[i] && !s.capture_lock[i] &&
          !(rd_take && s_axil_araddr == CAP_HI[i])) begin
        next_s.capture_value[i] = s.count;
        next_s.capture_flag[i] = 1'b1;
      end
      if (tick && cmp_match[i]) begin
        next_s.compare_flag[i] = 1'b1;
        if (pin_en[i]) next_s.compare_level_out[i] = level[i];
      end
    end
    // Pending flags reach the output as soon as their enables allow
    next_s.irq = next_s.control_reg_three[`FRCCT_CR3_GLOBAL_EN] & (
      (next_s.overflow_flag &
       next_s.control_reg_one[`FRCCT_CR1_OVF_EN]) |
      (next_s.capture_flag[0] &
       (next_s.control_reg_one[`FRCCT_CR1_SHARED_CAP_EN] |
        next_s.control_reg_three[`FRCCT_CR3_CAP1_EN])) |
      (next_s.capture_flag[1] &
       (next_s.control_reg_one[`FRCCT_CR1_SHARED_CAP_EN] |
        next_s.control_reg_three[`FRCCT_CR3_CAP2_EN])) |
      (next_s.compare_flag[0] &
       (next_s.control_reg_one[`FRCCT_CR1_SHARED_CMP_EN] |
        next_s.control_reg_three[`FRCCT_CR3_CMP1_EN])) |
      (next_s.compare_flag[1] &
       (next_s.control_reg_one[`FRCCT_CR1_SHARED_CMP_EN] |
        next_s.control_reg_three[`FRCCT_CR3_CMP2_EN])));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) s <= RESET_STATE;
    else s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_cnt_reload;
    wr_cnt_lo |=> s.count == 16'hFFFC;
  endproperty
  a_cnt_reload: assert property (p_cnt_reload)
    else $error("counter not reloaded after low write");
  property p_overflow;
    tick && s.count == 16'hFFFF && !wr_cnt_lo |=>
      s.overflow_flag && s.count == 16'h0000;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("rollover did not set overflow flag");
  property p_halt;
    halt_mode && !wr_cnt_lo |=> $stable(s.count);
  endproperty
  a_halt: assert property (p_halt)
    else $error("counter moved in halt");
  property p_div2;
    s.control_reg_two[3:2] == 2'b00 && tick |=> !raw_tick;
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by two ticked twice in a row");

  property p_cmp_hw;
    !do_write |=> $stable(s.compare_value);
  endproperty
  a_cmp_hw: assert property (p_cmp_hw)
    else $error("compare value changed without a write");

  property p_cmp_inhibit;
    s.compare_inhibit[1] && !s.compare_flag[1] |=> !s.compare_flag[1];
  endproperty
  a_cmp_inhibit: assert property (p_cmp_inhibit)
    else $error("compare matched while inhibited");

  property p_cap_lock;
    s.capture_lock[0] |=> $stable(s.capture_value[0]);
  endproperty
  a_cap_lock: assert property (p_cap_lock)
    else $error("capture overwritten while locked");

  property p_cap_flag;
    cap_edge[0] && !s.capture_lock[0] && !rd_take |=>
      s.capture_flag[0] && s.capture_value[0] == $past(s.count);
  endproperty
  a_cap_flag: assert property (p_cap_flag)
    else $error("capture event lost");

  property p_irq_gate;
    !s.control_reg_three[`FRCCT_CR3_GLOBAL_EN] |-> !combined_timer_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without global enable");

  property p_latch_hold;
    s.latched && !(rd_take && s_axil_araddr[3:0] == 4'h4) ##1
      s.latched |-> $stable(s.low_buf);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched low byte changed");

  c_overflow: cover property (tick && s.count == 16'hFFFF);
  c_capture: cover property (cap_edge[1] && !s.capture_lock[1]);
  c_match: cover property (tick && cmp_match[0] && pin_en[0]);
  c_irq: cover property ($rose(combined_timer_irq));

endmodule : frcct_timer

// [frcct_pin_model.sv]
// Far-side model of the timer pins: external clock source and capture
// sources. Assumes clk is the timer's internal clock; pins idle low.
`timescale 1ns/1ps

module frcct_pin_model (
  input wire logic clk,
  output logic ext_clock_pin,
  output logic capture_pin_one,
  output logic capture_pin_two
);
  initial begin
    ext_clock_pin = 1'h0;
    capture_pin_one = 1'h0;
    capture_pin_two = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Five clocks per level: active edges stay over four clocks apart
  task automatic ext_pulses(input int n);
    repeat (n) begin
      ext_clock_pin <= 1'h1;
      repeat (5) @(posedge clk);
      ext_clock_pin <= 1'h0;
      repeat (5) @(posedge clk);
    end
  endtask : ext_pulses

  // One full pulse: a rise, then a fall
  task automatic cap_pulse(input int ch);
    if (ch == 1) capture_pin_one <= 1'h1;
    else capture_pin_two <= 1'h1;
    repeat (5) @(posedge clk);
    if (ch == 1) capture_pin_one <= 1'h0;
    else capture_pin_two <= 1'h0;
    repeat (5) @(posedge clk);
  endtask : cap_pulse
endmodule : frcct_pin_model

// [frcct_timer_bench.sv]
// Self-checking bench of the capture/compare timer over AXI4-Lite.
// Assumes frcct_pin_model on the pins; external clock mode freezes count.
`timescale 1ns/1ps
`include "frcct_defs.svh"

module frcct_timer_bench;
  logic clk, reset_n, halt_mode;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic [1:0] s_axil_bresp, s_axil_rresp, last_resp;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic s_axil_rvalid, s_axil_rready;
  logic ext_clock_pin, capture_pin_one, capture_pin_two;
  logic compare_pin_one, compare_pin_one_oe;
  logic compare_pin_two, compare_pin_two_oe, combined_timer_irq;
  int n_mismatch = 0;
  int cmp_count = 0;

  frcct_timer dut (.clk(clk), .reset_n(reset_n),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready), .ext_clock_pin(ext_clock_pin),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
    .halt_mode(halt_mode), .compare_pin_one(compare_pin_one),
    .compare_pin_one_oe(compare_pin_one_oe),
    .compare_pin_two(compare_pin_two),
    .compare_pin_two_oe(compare_pin_two_oe),
    .combined_timer_irq(combined_timer_irq));
  frcct_pin_model pins (.clk(clk), .ext_clock_pin(ext_clock_pin),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic ci(input logic e);
    chk({15'h0000, combined_timer_irq}, {15'h0000, e}, "irq");
  endtask : ci

  // Unbounded waits; the watchdog covers a slave that never answers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axil_awaddr <= a;
    s_axil_awvalid <= 1'h1;
    s_axil_wdata <= {24'h00_0000, d};
    s_axil_wvalid <= 1'h1;
    s_axil_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axil_awready) s_axil_awvalid <= 1'h0;
      if (s_axil_wready) s_axil_wvalid <= 1'h0;
    end while (!s_axil_bvalid);
    last_resp = s_axil_bresp;
    s_axil_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axil_arready) s_axil_arvalid <= 1'h0;
    end while (!s_axil_rvalid);
    d = s_axil_rdata[7:0];
    last_resp = s_axil_rresp;
    s_axil_rready <= 1'h0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] e,
    input string what);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e}, what);
  endtask : rc

  // High byte first: the pairing the latch expects
  task automatic rd16(input logic [7:0] hi, input logic [7:0] lo,
    output logic [15:0] v);
    logic [7:0] h, l;
    rd(hi, h);
    rd(lo, l);
    v = {h, l};
  endtask : rd16

  task automatic c16(input logic [7:0] hi, input logic [7:0] lo,
    input logic [15:0] e, input string what);
    logic [15:0] v;
    rd16(hi, lo, v);
    chk(v, e, what);
  endtask : c16

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    c16(`FRCCT_OFF_CNT_HI, `FRCCT_OFF_CNT_LO, 16'hFFFC, "count");
    c16(`FRCCT_OFF_CMP1_HI, `FRCCT_OFF_CMP1_LO, 16'h8000, "cmp1");
    c16(`FRCCT_OFF_CMP2_HI, `FRCCT_OFF_CMP2_LO, 16'h8000, "cmp2");
    rc(`FRCCT_OFF_SR, 8'h00, "status");
    chk({15'h0000, compare_pin_one}, 16'h0000, "pin1");
    repeat (40) @(posedge clk);
    c16(`FRCCT_OFF_CNT_HI, `FRCCT_OFF_CNT_LO, 16'hFFFC, "halted");
    halt_mode <= 1'h0;
    $display("test reset done");
  endtask : t_reset

  task automatic t_axi;
    rc(8'h40, 8'h00, "unmapped data");
    chk({14'h0000, last_resp}, {14'h0000, `FRCCT_RESP_SLVERR}, "rresp");
    rc(8'h02, 8'h00, "misaligned data");
    chk({14'h0000, last_resp}, {14'h0000, `FRCCT_RESP_SLVERR}, "rresp");
    wr(8'h44, 8'h55);
    chk({14'h0000, last_resp}, {14'h0000, `FRCCT_RESP_SLVERR}, "bresp");
    s_axil_wstrb <= 4'h0;
    wr(`FRCCT_OFF_CR3, 8'hFF);
    s_axil_wstrb <= 4'hF;
    rc(`FRCCT_OFF_CR3, 8'h00, "strobe off");
    $display("test bus errors done");
  endtask : t_axi

  // About 83 clocks pass from reload to latch; window allows phase slack
  task automatic t_div;
    logic [15:0] v;
    int lim;
    for (int c = 0; c < 3; c++) begin
      wr(`FRCCT_OFF_CR2, 8'(c << 2));
      wr(`FRCCT_OFF_CNT_LO, 8'h00);
      repeat (80) @(posedge clk);
      rd16(`FRCCT_OFF_ALT_HI, `FRCCT_OFF_ALT_LO, v);
      v = v - 16'hFFFC;
      lim = (84 >> (c + 1)) - 3;
      chk({15'h0000, v >= lim && v <= lim + 6}, 16'h0001, "step");
    end
    $display("test prescaler done");
  endtask : t_div

  task automatic t_ext;
    logic [7:0] d;
    wr(`FRCCT_OFF_CR2, 8'h0D);
    wr(`FRCCT_OFF_CNT_LO, 8'h33);
    rd(`FRCCT_OFF_SR, d);
    pins.ext_pulses(2);
    c16(`FRCCT_OFF_CNT_HI, `FRCCT_OFF_CNT_LO, 16'hFFFE, "ext");
    wr(`FRCCT_OFF_CR2, 8'h0C);
    pins.ext_pulses(2);
    ci(1'h0);
    wr(`FRCCT_OFF_CR1, 8'h20);
    ci(1'h0);
    wr(`FRCCT_OFF_CR3, 8'h80);
    ci(1'h1);
    rc(`FRCCT_OFF_ALT_LO, 8'h00, "alt low");
    ci(1'h1);
    rc(`FRCCT_OFF_SR, 8'h20, "overflow");
    ci(1'h0);
    rc(`FRCCT_OFF_ALT_HI, 8'h00, "alt high");
    pins.ext_pulses(1);
    rc(`FRCCT_OFF_CNT_HI, 8'h00, "high again");
    rc(`FRCCT_OFF_CNT_LO, 8'h00, "latched low");
    rc(`FRCCT_OFF_CNT_LO, 8'h01, "live low");
    $display("test external clock done");
  endtask : t_ext

  task automatic t_cap;
    logic [7:0] d;
    wr(`FRCCT_OFF_CR1, 8'h10);
    wr(`FRCCT_OFF_CR3, 8'h00);
    rd(`FRCCT_OFF_SR, d);
    pins.cap_pulse(1);
    rc(`FRCCT_OFF_SR, 8'h80, "cap flag");
    c16(`FRCCT_OFF_CAP1_HI, `FRCCT_OFF_CAP1_LO, 16'h0001, "c1");
    pins.ext_pulses(1);
    pins.cap_pulse(1);
    c16(`FRCCT_OFF_CAP1_HI, `FRCCT_OFF_CAP1_LO, 16'h0002, "c1");
    rc(`FRCCT_OFF_CAP1_HI, 8'h00, "c1 high");
    pins.ext_pulses(1);
    pins.cap_pulse(1);
    rc(`FRCCT_OFF_CAP1_LO, 8'h02, "c1 held");
    c16(`FRCCT_OFF_CAP1_HI, `FRCCT_OFF_CAP1_LO, 16'h0002, "c1");
    rd(`FRCCT_OFF_SR, d);
    pins.cap_pulse(2);
    ci(1'h0);
    wr(`FRCCT_OFF_CR3, 8'h20);
    ci(1'h0);
    wr(`FRCCT_OFF_CR3, 8'hA0);
    ci(1'h1);
    c16(`FRCCT_OFF_CAP2_HI, `FRCCT_OFF_CAP2_LO, 16'h0003, "c2");
    ci(1'h0);
    wr(`FRCCT_OFF_CR1, 8'h90);
    wr(`FRCCT_OFF_CR3, 8'h80);
    pins.cap_pulse(1);
    ci(1'h1);
    rc(`FRCCT_OFF_SR, 8'h80, "cap flag");
    ci(1'h0);
    $display("test capture done");
  endtask : t_cap

  // A match lands as the counter leaves the compare value, so flags
  // are read one count past it and a held match cannot set them again
  task automatic t_cmp;
    logic [7:0] d;
    wr(`FRCCT_OFF_CMP1_HI, 8'h00);
    wr(`FRCCT_OFF_CMP1_LO, 8'h05);
    wr(`FRCCT_OFF_CR1, 8'h03);
    wr(`FRCCT_OFF_CR2, 8'h8C);
    wr(`FRCCT_OFF_CR3, 8'h90);
    rd(`FRCCT_OFF_SR, d);
    chk({15'h0000, compare_pin_one_oe}, 16'h0001, "oe1");
    ci(1'h0);
    pins.ext_pulses(3);
    chk({15'h0000, compare_pin_one}, 16'h0001, "pin1");
    ci(1'h1);
    rc(`FRCCT_OFF_SR, 8'h40, "cmp flag");
    ci(1'h0);
    wr(`FRCCT_OFF_CMP1_LO, 8'h07);
    pins.ext_pulses(2);
    ci(1'h1);
    rc(`FRCCT_OFF_CMP1_LO, 8'h07, "cmp1 low");
    ci(1'h0);
    wr(`FRCCT_OFF_CNT_LO, 8'h00);
    wr(`FRCCT_OFF_CMP2_HI, 8'hFF);
    wr(`FRCCT_OFF_CMP2_LO, 8'hFE);
    wr(`FRCCT_OFF_CMP2_HI, 8'hFF);
    pins.ext_pulses(3);
    rc(`FRCCT_OFF_SR, 8'h00, "inhibited");
    wr(`FRCCT_OFF_CNT_LO, 8'h00);
    wr(`FRCCT_OFF_CMP2_LO, 8'hFE);
    pins.ext_pulses(3);
    ci(1'h0);
    rc(`FRCCT_OFF_SR, 8'h08, "cmp2 flag");
    chk({15'h0000, compare_pin_two_oe}, 16'h0000, "oe2");
    chk({15'h0000, compare_pin_two}, 16'h0000, "pin2");
    $display("test compare done");
  endtask : t_cmp

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'h0;
    halt_mode = 1'h1;
    s_axil_awaddr = 8'h00;
    s_axil_awvalid = 1'h0;
    s_axil_wdata = 32'h0000_0000;
    s_axil_wstrb = 4'hF;
    s_axil_wvalid = 1'h0;
    s_axil_bready = 1'h0;
    s_axil_araddr = 8'h00;
    s_axil_arvalid = 1'h0;
    s_axil_rready = 1'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'h1;
    t_reset;
    t_axi;
    t_div;
    t_ext;
    t_cap;
    t_cmp;
    tally_and_finish;
  end

  // Tests need under a thousand clocks; the watchdog allows 20000
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule : frcct_timer_bench
